/* verilog/aoc_pkg.sv */
// Constants, register map and carrier types of the auxiliary output control.
// Assumes a 32-bit register port with byte addresses and one aligned word per register.
package aoc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_BLK = 4;
    localparam int unsigned NUM_REC = 2;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LIM1_SRC = 8'h04;
    localparam logic [7:0] OFF_LIM2_SRC = 8'h08;
    localparam logic [7:0] OFF_REC_FEED = 8'h0C;
    localparam logic [7:0] OFF_REC1_MIN = 8'h10;
    localparam logic [7:0] OFF_REC1_MAX = 8'h14;
    localparam logic [7:0] OFF_REC2_MIN = 8'h18;
    localparam logic [7:0] OFF_REC2_MAX = 8'h1C;
    localparam logic [7:0] OFF_STATUS = 8'h20;

    localparam int unsigned CTRL_REC_EN = 0;
    localparam int unsigned CTRL_REF_EN = 2;
    localparam int unsigned CTRL_TRIG_EN = 3;
    localparam int unsigned CTRL_LIM_EN = 4;
    localparam int unsigned CTRL_LIM_POL = 6;
    localparam int unsigned SRC_BLK_LSB = 0;
    localparam int unsigned SRC_MODE_LSB = 2;
    localparam int unsigned ST_REFUSED = 0;
    localparam int unsigned ST_LIM_LVL = 1;
    localparam int unsigned ST_REC_OK = 3;

    localparam logic [31:0] DBM_LO = 32'hFFFFC568;
    localparam logic [31:0] DBM_HI = 32'h000007D0;
    localparam logic [31:0] PCT_HI = 32'h00002710;
    localparam int unsigned W_MANT_LSB = 0;
    localparam int unsigned W_EXP_LSB = 10;
    localparam logic [9:0] W_MANT_LO = 10'h001;
    localparam logic [9:0] W_MANT_HI = 10'h3E8;
    localparam logic [4:0] W_EXP_HI = 5'h0E;
    localparam logic [16:0] W_TOP_ZERO = 17'h00000;

    localparam logic [31:0] RST_REC_MIN = DBM_LO;
    localparam logic [31:0] RST_REC_MAX = DBM_HI;
    localparam logic [1:0] RST_FEED = 2'h0;
    localparam logic [1:0] RST_BLK = 2'h0;

    typedef enum logic [1:0] {
        AOC_UNIT_DBM = 2'h0,
        AOC_UNIT_WATT = 2'h1,
        AOC_UNIT_PCT = 2'h2,
        AOC_UNIT_BAD = 2'h3
    } aoc_unit_type;

    typedef enum logic [1:0] {
        AOC_SRC_NONE = 2'h0,
        AOC_SRC_LOWER = 2'h1,
        AOC_SRC_UPPER = 2'h2,
        AOC_SRC_EITHER = 2'h3
    } aoc_mode_type;

    typedef struct packed {
        aoc_mode_type mode;
        logic [1:0] blk;
    } aoc_src_type;

    typedef struct packed {
        logic en;
        logic [1:0] feed;
        logic [31:0] min;
        logic [31:0] max;
    } aoc_rec_cfg_type;

    typedef struct packed {
        logic [1:0] rec_en;
        logic ref_en;
        logic trig_en;
        logic [1:0] lim_en;
        logic [1:0] lim_pol;
        aoc_src_type [1:0] src;
        logic [1:0][31:0] min;
        logic [1:0][31:0] max;
        logic refused;
        logic [31:0] rd_data;
    } aoc_main_type;

    typedef struct packed {
        logic out;
    } aoc_drv_type;

    typedef struct packed {
        logic [1:0][1:0] feed;
    } aoc_feed_type;
endpackage

/* verilog/aoc_feed_store.sv */
// Recorder source selection store, kept across the functional reset.
// Assumes only the power-on reset clears it; the main reset leaves it alone.
`timescale 1ns/1ps
module aoc_feed_store (
    // Clock and power-on reset.
    input logic mclk_i,
    input logic por_n_i,
    // Write port.
    input logic wr_i,
    input logic [3:0] wr_data_i,
    // Stored selection.
    output logic [1:0][1:0] feed_o
);
    aoc_pkg::aoc_feed_type st_r;
    aoc_pkg::aoc_feed_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (wr_i) begin
            st_nxt.feed = wr_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge por_n_i) begin
        if (!por_n_i) begin
            st_r.feed <= {aoc_pkg::RST_FEED, aoc_pkg::RST_FEED};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign feed_o = st_r.feed;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!por_n_i);

    chk_feed_write_kept: assert property (wr_i |=> feed_o == $past(wr_data_i))
        else $error("recorder feed write not stored");
    chk_feed_idle_hold: assert property (!wr_i |=> feed_o == $past(feed_o))
        else $error("recorder feed changed without a write");
endmodule

/* verilog/aoc_limit_drv.sv */
// Drives one limit-fail output from the selected measurement block limit test.
// Assumes the fail inputs are synchronous levels from the limit test logic.
`timescale 1ns/1ps
module aoc_limit_drv (
    // Clock and reset.
    input logic mclk_i,
    input logic arst_n_i,
    // Settings.
    input logic en_i,
    input logic pol_high_i,
    input aoc_pkg::aoc_src_type src_i,
    // Limit test results.
    input logic [3:0] lower_fail_i,
    input logic [3:0] upper_fail_i,
    // Pin level.
    output logic out_o
);
    aoc_pkg::aoc_drv_type st_r;
    aoc_pkg::aoc_drv_type st_nxt;
    logic fail;

    always_comb begin
        fail = 1'b0;
        case (src_i.mode)
            aoc_pkg::AOC_SRC_LOWER: fail = lower_fail_i[src_i.blk];
            aoc_pkg::AOC_SRC_UPPER: fail = upper_fail_i[src_i.blk];
            aoc_pkg::AOC_SRC_EITHER: begin
                fail = lower_fail_i[src_i.blk] | upper_fail_i[src_i.blk];
            end
            default: fail = 1'b0;
        endcase
        st_nxt.out = !pol_high_i;
        if (en_i && fail) begin
            st_nxt.out = pol_high_i;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r.out <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out_o = st_r.out;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_fail_seen;
        en_i && fail;
    endsequence

    chk_disabled_idle_level: assert property (!en_i |=> out_o == !$past(pol_high_i))
        else $error("disabled limit output not at inactive level");
    chk_fail_drive_level: assert property (s_fail_seen |=> out_o == $past(pol_high_i))
        else $error("limit fail did not drive selected level");
    chk_lower_only_mode: assert property (en_i && src_i.mode == aoc_pkg::AOC_SRC_LOWER
        && upper_fail_i[src_i.blk] && !lower_fail_i[src_i.blk] |=> out_o == !$past(pol_high_i))
        else $error("lower-only source reacted to upper fail");
endmodule

/* verilog/aoc_aux_ctrl.sv */
// Auxiliary output control: recorder scaling, output enables and limit-fail pins.
// Assumes a register master on the same clock and synchronous limit test levels.
`timescale 1ns/1ps
module aoc_aux_ctrl (
    // Clock and resets.
    input logic mclk_i,
    input logic arst_n_i,
    input logic por_n_i,
    // Register port.
    input logic [7:0] addr_i,
    input logic [31:0] wr_data_i,
    input logic wr_i,
    input logic rd_i,
    output logic [31:0] rd_data_o,
    // Measurement blocks.
    input aoc_pkg::aoc_unit_type [3:0] unit_i,
    input logic [3:0] lower_fail_i,
    input logic [3:0] upper_fail_i,
    // Recorder settings.
    output aoc_pkg::aoc_rec_cfg_type [1:0] rec_cfg_o,
    // Rear-panel enables and pins.
    output logic ref_source_en_o,
    output logic trig_out_en_o,
    output logic limit_out_first_o,
    output logic limit_out_second_o
);
    aoc_pkg::aoc_main_type st_r;
    aoc_pkg::aoc_main_type st_nxt;
    logic [1:0][1:0] feed;
    logic feed_wr;
    logic refuse;
    logic [1:0] rec_ok;
    aoc_pkg::aoc_unit_type [1:0] rec_unit;

    // Checks a scale value against the range of the given unit.
    function automatic logic in_range(input aoc_pkg::aoc_unit_type u,
                                      input logic [31:0] v);
        logic ok;
        ok = 1'b0;
        if (u == aoc_pkg::AOC_UNIT_DBM) begin
            ok = ($signed(v) >= $signed(aoc_pkg::DBM_LO))
                && ($signed(v) <= $signed(aoc_pkg::DBM_HI));
        end else if (u == aoc_pkg::AOC_UNIT_WATT) begin
            ok = (v[31:15] == aoc_pkg::W_TOP_ZERO)
                && (v[aoc_pkg::W_MANT_LSB +: 10] >= aoc_pkg::W_MANT_LO)
                && (v[aoc_pkg::W_MANT_LSB +: 10] <= aoc_pkg::W_MANT_HI)
                && (v[aoc_pkg::W_EXP_LSB +: 5] <= aoc_pkg::W_EXP_HI);
        end else if (u == aoc_pkg::AOC_UNIT_PCT) begin
            ok = v <= aoc_pkg::PCT_HI;
        end
        return ok;
    endfunction

    // Packs a limit source for readback.
    function automatic logic [31:0] src_word(input aoc_pkg::aoc_src_type s);
        return {28'h0000000, s};
    endfunction

    aoc_feed_store u_feed (
        .mclk_i(mclk_i),
        .por_n_i(por_n_i),
        .wr_i(feed_wr),
        .wr_data_i(wr_data_i[3:0]),
        .feed_o(feed)
    );

    aoc_limit_drv u_lim_first (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .en_i(st_r.lim_en[0]),
        .pol_high_i(st_r.lim_pol[0]),
        .src_i(st_r.src[0]),
        .lower_fail_i(lower_fail_i),
        .upper_fail_i(upper_fail_i),
        .out_o(limit_out_first_o)
    );

    aoc_limit_drv u_lim_second (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .en_i(st_r.lim_en[1]),
        .pol_high_i(st_r.lim_pol[1]),
        .src_i(st_r.src[1]),
        .lower_fail_i(lower_fail_i),
        .upper_fail_i(upper_fail_i),
        .out_o(limit_out_second_o)
    );

    // The unit of each recorder follows its selected source block.
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            rec_unit[k] = unit_i[feed[k]];
            rec_ok[k] = in_range(rec_unit[k], st_r.min[k])
                && in_range(rec_unit[k], st_r.max[k]);
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_data = '0;
        refuse = 1'b0;
        feed_wr = 1'b0;
        if (wr_i) begin
            if (addr_i == aoc_pkg::OFF_CTRL) begin
                st_nxt.rec_en = wr_data_i[aoc_pkg::CTRL_REC_EN +: 2];
                st_nxt.ref_en = wr_data_i[aoc_pkg::CTRL_REF_EN];
                st_nxt.trig_en = wr_data_i[aoc_pkg::CTRL_TRIG_EN];
                st_nxt.lim_en = wr_data_i[aoc_pkg::CTRL_LIM_EN +: 2];
                st_nxt.lim_pol = wr_data_i[aoc_pkg::CTRL_LIM_POL +: 2];
            end else if (addr_i == aoc_pkg::OFF_LIM1_SRC) begin
                if (wr_data_i[aoc_pkg::SRC_MODE_LSB +: 2] == aoc_pkg::AOC_SRC_NONE) begin
                    refuse = 1'b1;
                end else begin
                    st_nxt.src[0] = aoc_pkg::aoc_src_type'(wr_data_i[3:0]);
                end
            end else if (addr_i == aoc_pkg::OFF_LIM2_SRC) begin
                if (wr_data_i[aoc_pkg::SRC_MODE_LSB +: 2] == aoc_pkg::AOC_SRC_NONE) begin
                    refuse = 1'b1;
                end else begin
                    st_nxt.src[1] = aoc_pkg::aoc_src_type'(wr_data_i[3:0]);
                end
            end else if (addr_i == aoc_pkg::OFF_REC_FEED) begin
                feed_wr = 1'b1;
            end else if (addr_i == aoc_pkg::OFF_REC1_MIN) begin
                if (in_range(rec_unit[0], wr_data_i)) begin
                    st_nxt.min[0] = wr_data_i;
                end else begin
                    refuse = 1'b1;
                end
            end else if (addr_i == aoc_pkg::OFF_REC1_MAX) begin
                if (in_range(rec_unit[0], wr_data_i)) begin
                    st_nxt.max[0] = wr_data_i;
                end else begin
                    refuse = 1'b1;
                end
            end else if (addr_i == aoc_pkg::OFF_REC2_MIN) begin
                if (in_range(rec_unit[1], wr_data_i)) begin
                    st_nxt.min[1] = wr_data_i;
                end else begin
                    refuse = 1'b1;
                end
            end else if (addr_i == aoc_pkg::OFF_REC2_MAX) begin
                if (in_range(rec_unit[1], wr_data_i)) begin
                    st_nxt.max[1] = wr_data_i;
                end else begin
                    refuse = 1'b1;
                end
            end else if (addr_i == aoc_pkg::OFF_STATUS) begin
                if (wr_data_i[aoc_pkg::ST_REFUSED]) begin
                    st_nxt.refused = 1'b0;
                end
            end
        end
        if (refuse) begin
            st_nxt.refused = 1'b1;
        end
        if (rd_i) begin
            if (addr_i == aoc_pkg::OFF_CTRL) begin
                st_nxt.rd_data = {24'h000000, st_r.lim_pol, st_r.lim_en,
                    st_r.trig_en, st_r.ref_en, st_r.rec_en};
            end else if (addr_i == aoc_pkg::OFF_LIM1_SRC) begin
                st_nxt.rd_data = src_word(st_r.src[0]);
            end else if (addr_i == aoc_pkg::OFF_LIM2_SRC) begin
                st_nxt.rd_data = src_word(st_r.src[1]);
            end else if (addr_i == aoc_pkg::OFF_REC_FEED) begin
                st_nxt.rd_data = {28'h0000000, feed};
            end else if (addr_i == aoc_pkg::OFF_REC1_MIN) begin
                st_nxt.rd_data = st_r.min[0];
            end else if (addr_i == aoc_pkg::OFF_REC1_MAX) begin
                st_nxt.rd_data = st_r.max[0];
            end else if (addr_i == aoc_pkg::OFF_REC2_MIN) begin
                st_nxt.rd_data = st_r.min[1];
            end else if (addr_i == aoc_pkg::OFF_REC2_MAX) begin
                st_nxt.rd_data = st_r.max[1];
            end else if (addr_i == aoc_pkg::OFF_STATUS) begin
                st_nxt.rd_data = {27'h0000000, rec_ok, limit_out_second_o,
                    limit_out_first_o, st_r.refused};
            end else begin
                st_nxt.rd_data = '0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r.rec_en <= 2'h0;
            st_r.ref_en <= 1'b0;
            st_r.trig_en <= 1'b0;
            st_r.lim_en <= 2'h0;
            st_r.lim_pol <= 2'h0;
            st_r.src[0] <= {aoc_pkg::AOC_SRC_UPPER, aoc_pkg::RST_BLK};
            st_r.src[1] <= {aoc_pkg::AOC_SRC_UPPER, aoc_pkg::RST_BLK};
            st_r.min[0] <= aoc_pkg::RST_REC_MIN;
            st_r.min[1] <= aoc_pkg::RST_REC_MIN;
            st_r.max[0] <= aoc_pkg::RST_REC_MAX;
            st_r.max[1] <= aoc_pkg::RST_REC_MAX;
            st_r.refused <= 1'b0;
            st_r.rd_data <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // The recorder drive receives enable, source and both scale limits.
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            rec_cfg_o[k].en = st_r.rec_en[k];
            rec_cfg_o[k].feed = feed[k];
            rec_cfg_o[k].min = st_r.min[k];
            rec_cfg_o[k].max = st_r.max[k];
        end
    end

    assign rd_data_o = st_r.rd_data;
    assign ref_source_en_o = st_r.ref_en;
    assign trig_out_en_o = st_r.trig_en;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_bad_min1;
        wr_i && addr_i == aoc_pkg::OFF_REC1_MIN && !in_range(rec_unit[0], wr_data_i);
    endsequence

    sequence s_good_max2;
        wr_i && addr_i == aoc_pkg::OFF_REC2_MAX && in_range(rec_unit[1], wr_data_i);
    endsequence

    sequence s_ctrl_read;
        rd_i && addr_i == aoc_pkg::OFF_CTRL;
    endsequence

    sequence s_ctrl_write;
        wr_i && addr_i == aoc_pkg::OFF_CTRL;
    endsequence

    sequence s_feed_read;
        rd_i && addr_i == aoc_pkg::OFF_REC_FEED;
    endsequence

    sequence s_status_read;
        rd_i && addr_i == aoc_pkg::OFF_STATUS;
    endsequence

    sequence s_good_src1;
        wr_i && addr_i == aoc_pkg::OFF_LIM1_SRC && wr_data_i[3:2] != 2'h0;
    endsequence

    chk_reset_scale_defaults: assert property ($rose(arst_n_i) |->
        st_r.min[0] == aoc_pkg::DBM_LO && st_r.max[1] == aoc_pkg::DBM_HI)
        else $error("scale limits not at reset defaults");
    chk_reset_lim_defaults: assert property ($rose(arst_n_i) |-> st_r.lim_pol == 2'h0
        && st_r.src[0].mode == aoc_pkg::AOC_SRC_UPPER && st_r.lim_en == 2'h0)
        else $error("limit pin settings not at reset defaults");
    chk_bad_scale_kept: assert property (s_bad_min1 |=>
        st_r.min[0] == $past(st_r.min[0]) && st_r.refused)
        else $error("out-of-range scale value was stored");
    chk_good_scale_unit: assert property (s_good_max2 |=>
        rec_cfg_o[1].max == $past(wr_data_i) && st_r.refused == $past(st_r.refused))
        else $error("valid scale value not stored");
    chk_ctrl_readback: assert property (s_ctrl_read |=>
        rd_data_o[7:0] == {$past(st_r.lim_pol), $past(st_r.lim_en), $past(trig_out_en_o),
        $past(ref_source_en_o), $past(st_r.rec_en)})
        else $error("enable readback wrong");
    chk_src_readback: assert property (rd_i && addr_i == aoc_pkg::OFF_LIM2_SRC |=>
        rd_data_o == {28'h0000000, $past(st_r.src[1])})
        else $error("source readback wrong");
    chk_src_none_refused: assert property (wr_i && addr_i == aoc_pkg::OFF_LIM1_SRC
        && wr_data_i[3:2] == 2'h0 |=> st_r.src[0] == $past(st_r.src[0]) && st_r.refused)
        else $error("empty source selection accepted");
    chk_read_one_cycle: assert property (!rd_i |=> rd_data_o == 32'h00000000)
        else $error("read data outside its cycle");
    chk_refuse_set_wins: assert property (refuse && wr_i |=> st_r.refused)
        else $error("refused flag lost");
    chk_ctrl_write_applied: assert property (s_ctrl_write |=>
        ref_source_en_o == $past(wr_data_i[aoc_pkg::CTRL_REF_EN])
        && trig_out_en_o == $past(wr_data_i[aoc_pkg::CTRL_TRIG_EN]))
        else $error("output enables not applied");
    chk_feed_readback: assert property (s_feed_read |=>
        rd_data_o == {28'h0000000, $past(feed)})
        else $error("recorder feed readback wrong");
    chk_status_readback: assert property (s_status_read |=>
        rd_data_o[2:0] == {$past(limit_out_second_o), $past(limit_out_first_o),
        $past(st_r.refused)})
        else $error("status readback wrong");
    chk_src_write_stored: assert property (s_good_src1 |=>
        st_r.src[0] == $past(wr_data_i[3:0]))
        else $error("limit source write not stored");
endmodule

/* tb/aoc_host_model.sv */
// Host controller model: issues register writes and reads on the plain register port.
// Assumes one bench clock; each task starts and ends on a rising edge.
`timescale 1ns/1ps
module aoc_host_model (
    // Clock.
    input wire logic mclk_i,
    // Register port.
    output logic [7:0] addr_o,
    output logic [31:0] wr_data_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 8'h00;
        wr_data_o = 32'h00000000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // A source is sent as one mode and one block code, so an either-fail pair names one block.
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        wr_data_o <= d;
        wr_o <= 1'b1;
        @(posedge mclk_i);
        wr_o <= 1'b0;
        wr_data_o <= ~d;
    endtask

    task automatic get(input logic [7:0] a);
        @(posedge mclk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge mclk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
    endtask
endmodule

/* tb/aoc_aux_ctrl_tb.sv */
// Self-checking testbench of the auxiliary output control.
// Assumes the host model drives the register port; the bench drives units and fail levels.
`timescale 1ns/1ps
module aoc_aux_ctrl_tb;
    logic mclk_i;
    logic arst_n_i;
    logic por_n_i;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rd_data;
    aoc_pkg::aoc_unit_type [3:0] unit;
    logic [3:0] lo_fail;
    logic [3:0] up_fail;
    aoc_pkg::aoc_rec_cfg_type [1:0] rec_cfg;
    logic ref_en;
    logic trig_en;
    logic pin1;
    logic pin2;
    logic rd_d;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int errors;
    int cmp_count;
    logic [1:0] t_unit [11] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 3};
    logic [31:0] t_val [11] = '{32'hFFFFC568, 32'hFFFFC567, 32'h000007D0, 32'h000007D1,
        32'h00003BE8, 32'h00003BE9, 32'h00003C01, 32'h00000000, 32'h00002710, 32'h00002711,
        32'h00000001};
    logic t_ok [11] = '{1, 0, 1, 0, 1, 0, 0, 0, 1, 0, 0};

    aoc_host_model aoc_host_model_inst (.mclk_i(mclk_i), .addr_o(addr), .wr_data_o(wdata),
        .wr_o(wr), .rd_o(rd));

    aoc_aux_ctrl aoc_aux_ctrl_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .por_n_i(por_n_i),
        .addr_i(addr), .wr_data_i(wdata), .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data),
        .unit_i(unit), .lower_fail_i(lo_fail), .upper_fail_i(up_fail), .rec_cfg_o(rec_cfg),
        .ref_source_en_o(ref_en), .trig_out_en_o(trig_en), .limit_out_first_o(pin1),
        .limit_out_second_o(pin2));

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic cmp_val(input string what, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, e, s);
        end
    endtask

    task automatic cmp_bit(input string what, input logic e, input logic s);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s: expected %b, seen %b", what, e, s);
        end
    endtask

    task automatic end_sim;
        errors = errors + exp_q.size();
        $display("errors %0d, comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        aoc_host_model_inst.get(a);
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken at that edge.
    always @(posedge mclk_i) begin
        if (rd_d && exp_q.size() > 0) begin
            cmp_val("read data", exp_q[0] & msk_q[0], rd_data & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        rd_d <= rd;
    end

    function automatic logic lvl(input logic en, input logic pol, input logic [3:0] s);
        logic f;
        f = (s[2] & lo_fail[s[1:0]]) | (s[3] & up_fail[s[1:0]]);
        return (en & f) ? pol : ~pol;
    endfunction

    task automatic chk_pins(input logic [3:0] s1, input logic [3:0] s2, input logic [1:0] en,
        input logic [1:0] pol);
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        cmp_bit("first pin", lvl(en[0], pol[0], s1), pin1);
        cmp_bit("second pin", lvl(en[1], pol[1], s2), pin2);
        @(posedge mclk_i);
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        errors++;
        end_sim();
    end

    initial begin
        logic [31:0] v;
        logic [1:0] pol;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [31:0] prev;
        errors = 0;
        cmp_count = 0;
        arst_n_i = 1'b0;
        por_n_i = 1'b0;
        unit = '{default: aoc_pkg::AOC_UNIT_DBM};
        lo_fail = 4'h0;
        up_fail = 4'h0;
        void'($urandom(32'h6ECE11D8));
        repeat (8) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        por_n_i <= 1'b1;
        chk_rd(aoc_pkg::OFF_CTRL, 32'h00000000, 32'hFFFFFFFF);
        chk_rd(aoc_pkg::OFF_LIM1_SRC, 32'h00000008, 32'h0000000F);
        chk_rd(aoc_pkg::OFF_LIM2_SRC, 32'h00000008, 32'h0000000F);
        chk_rd(aoc_pkg::OFF_REC1_MIN, 32'hFFFFC568, 32'hFFFFFFFF);
        chk_rd(aoc_pkg::OFF_REC2_MIN, 32'hFFFFC568, 32'hFFFFFFFF);
        chk_rd(aoc_pkg::OFF_REC1_MAX, 32'h000007D0, 32'hFFFFFFFF);
        chk_rd(aoc_pkg::OFF_REC2_MAX, 32'h000007D0, 32'hFFFFFFFF);
        cmp_val("enables", 32'h0, {ref_en, trig_en, rec_cfg[1].en, rec_cfg[0].en});
        lo_fail <= 4'hF;
        up_fail <= 4'hF;
        chk_pins(4'h8, 4'h8, 2'b00, 2'b00);
        aoc_host_model_inst.put(aoc_pkg::OFF_CTRL, 32'h00000030);
        chk_pins(4'h8, 4'h8, 2'b11, 2'b00);
        up_fail <= 4'h0;
        chk_pins(4'h8, 4'h8, 2'b11, 2'b00);
        for (int i = 0; i < 4; i++) begin
            v = $urandom & 32'h000000FF;
            aoc_host_model_inst.put(aoc_pkg::OFF_CTRL, v);
            @(negedge mclk_i);
            cmp_val("enables", {28'h0, v[2], v[3], v[1:0]},
                {ref_en, trig_en, rec_cfg[1].en, rec_cfg[0].en});
            chk_rd(aoc_pkg::OFF_CTRL, v, 32'h000000FF);
        end
        for (int b = 0; b < 4; b++) begin
            for (int m = 1; m < 4; m++) begin
                pol = 2'($urandom);
                s1 = {2'(m), 2'(b)};
                s2 = {2'(m), 2'(3 - b)};
                aoc_host_model_inst.put(aoc_pkg::OFF_CTRL, {24'h0, pol, 6'h30});
                aoc_host_model_inst.put(aoc_pkg::OFF_LIM1_SRC, {28'h0, s1});
                aoc_host_model_inst.put(aoc_pkg::OFF_LIM2_SRC, {28'h0, s2});
                chk_rd(aoc_pkg::OFF_LIM1_SRC, {28'h0, s1}, 32'h0000000F);
                chk_rd(aoc_pkg::OFF_LIM2_SRC, {28'h0, s2}, 32'h0000000F);
                chk_rd(aoc_pkg::OFF_CTRL, {24'h0, pol, 6'h30}, 32'h000000FF);
                for (int k = 0; k < 3; k++) begin
                    lo_fail <= 4'($urandom);
                    up_fail <= 4'($urandom);
                    chk_pins(s1, s2, 2'b11, pol);
                end
            end
        end
        aoc_host_model_inst.put(aoc_pkg::OFF_CTRL, 32'h000000C0);
        lo_fail <= 4'hF;
        up_fail <= 4'hF;
        chk_pins(s1, s2, 2'b00, 2'b11);
        aoc_host_model_inst.put(aoc_pkg::OFF_LIM1_SRC, 32'h00000009);
        aoc_host_model_inst.put(aoc_pkg::OFF_LIM1_SRC, 32'h00000003);
        chk_rd(aoc_pkg::OFF_LIM1_SRC, 32'h00000009, 32'h0000000F);
        chk_rd(aoc_pkg::OFF_STATUS, 32'h00000001, 32'h00000001);
        aoc_host_model_inst.put(aoc_pkg::OFF_STATUS, 32'h00000001);
        chk_rd(aoc_pkg::OFF_STATUS, 32'h00000000, 32'h00000001);
        prev = 32'h000007D0;
        for (int i = 0; i < 11; i++) begin
            unit[0] <= aoc_pkg::aoc_unit_type'(t_unit[i]);
            aoc_host_model_inst.put(aoc_pkg::OFF_REC1_MAX, t_val[i]);
            prev = t_ok[i] ? t_val[i] : prev;
            chk_rd(aoc_pkg::OFF_REC1_MAX, prev, 32'hFFFFFFFF);
        end
        unit[0] <= aoc_pkg::AOC_UNIT_DBM;
        unit[1] <= aoc_pkg::AOC_UNIT_PCT;
        aoc_host_model_inst.put(aoc_pkg::OFF_REC_FEED, 32'h00000001);
        v = $urandom % 10001;
        aoc_host_model_inst.put(aoc_pkg::OFF_REC1_MIN, v);
        chk_rd(aoc_pkg::OFF_REC1_MIN, v, 32'hFFFFFFFF);
        aoc_host_model_inst.put(aoc_pkg::OFF_REC1_MAX, 32'h00002710);
        aoc_host_model_inst.put(aoc_pkg::OFF_REC_FEED, 32'h00000000);
        aoc_host_model_inst.put(aoc_pkg::OFF_REC1_MAX, 32'h00001388);
        aoc_host_model_inst.put(aoc_pkg::OFF_REC1_MIN, 32'hFFFFC567);
        chk_rd(aoc_pkg::OFF_REC1_MIN, v, 32'hFFFFFFFF);
        aoc_host_model_inst.put(aoc_pkg::OFF_REC2_MAX, 32'h000003E8);
        chk_rd(aoc_pkg::OFF_REC2_MAX, 32'h000003E8, 32'hFFFFFFFF);
        chk_rd(aoc_pkg::OFF_REC1_MAX, 32'h00002710, 32'hFFFFFFFF);
        cmp_val("recorder max", 32'h00002710, rec_cfg[0].max);
        chk_rd(8'h24, 32'h00000000, 32'hFFFFFFFF);
        aoc_host_model_inst.put(8'h40, $urandom);
        chk_rd(aoc_pkg::OFF_CTRL, 32'h000000C0, 32'hFFFFFFFF);
        aoc_host_model_inst.put(aoc_pkg::OFF_REC_FEED, 32'h0000000E);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        chk_rd(aoc_pkg::OFF_REC_FEED, 32'h0000000E, 32'h0000000F);
        chk_rd(aoc_pkg::OFF_CTRL, 32'h00000000, 32'hFFFFFFFF);
        chk_rd(aoc_pkg::OFF_REC1_MIN, 32'hFFFFC568, 32'hFFFFFFFF);
        cmp_val("recorder feed", 32'h3, {30'h0, rec_cfg[1].feed});
        repeat (3) @(posedge mclk_i);
        end_sim();
    end
endmodule
